// [logic/line_router_pkg.sv]
// constants and types shared by the line router and its character injector
package line_router_pkg;
  localparam int CLK_HZ = 125_000_000;
  localparam int BAUD_DEFAULT = 115_200;
  localparam logic [15:0] DIV_DEFAULT = 16'(CLK_HZ / BAUD_DEFAULT);

  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_INJ_CFG = 8'h10;
  localparam logic [7:0] OFS_INJ_DATA = 8'h14;
  localparam logic [7:0] OFS_INJ_BREAK = 8'h18;
  localparam logic [7:0] OFS_TAP_SEL = 8'h1C;
  localparam logic [2:0] ROUTE_PAGE = 3'h1;

  localparam int CTRL_APPLY = 0;
  localparam int CTRL_BTN = 1;
  localparam int CTRL_TAP_POST = 2;
  localparam int CTRL_LOAD_DFLT = 3;
  localparam int STAT_FAULT = 0;
  localparam int STAT_INJ_BUSY = 1;

  localparam int IRQ_W = 3;
  localparam int IRQ_APPLIED = 0;
  localparam int IRQ_FAULT = 1;
  localparam int IRQ_INJ_DONE = 2;

  localparam int CFG_W = 22;
  localparam int CFG_DIV_LSB = 0;
  localparam int CFG_PAR_LSB = 16;
  localparam int CFG_PAR_ERR = 18;
  localparam int CFG_NINE = 19;
  localparam int CFG_SHORT_STOP = 20;
  localparam int CFG_DROP_BIT = 21;
  localparam logic [CFG_W-1:0] CFG_RESET = {6'h00, DIV_DEFAULT};

  localparam int DATA_LSB = 0;
  localparam int GAP_LSB = 16;
  localparam logic [6:0] GAP_MIN = 7'h01;
  localparam logic [15:0] BRK_MIN = 16'h0001;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h2;

  localparam int TAP0_LSB = 0;
  localparam int TAP1_LSB = 4;
  localparam logic [7:0] TAP_RESET = 8'h40;

  localparam logic [4:0] SRC_HIGH = 5'h10;
  localparam logic [4:0] SRC_BTN = 5'h12;
  localparam logic [4:0] SRC_INJ = 5'h13;
  localparam logic [1:0] SRC_KIND_IN = 2'h0;
  localparam logic [1:0] SRC_KIND_OUT = 2'h1;
  localparam logic [7:0][4:0] ROUTE_DEFAULT = {5'h03, 5'h02, 5'h01, 5'h00,
                                               5'h07, 5'h06, 5'h05, 5'h04};

  typedef enum logic [2:0] {INJ_IDLE, INJ_START, INJ_DATA, INJ_PAR, INJ_STOP,
                            INJ_GAP, INJ_BRK} injState_t;
endpackage

// [logic/char_injector.sv]
// serial character generator with gaps, forced errors and breaks
`timescale 1ns/1ps
module char_injector (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [8:0] data,
  input wire logic [6:0] gap,
  input wire logic brkStart,
  input wire logic [15:0] brkLen,
  input wire logic [line_router_pkg::CFG_W-1:0] cfg,
  output logic txBit,
  output logic busy,
  output logic done
);
  import line_router_pkg::*;

  typedef struct packed {
    injState_t st;
    logic [15:0] div;
    logic [15:0] cnt;
    logic [15:0] left;
    logic [3:0] bitCnt;
    logic [3:0] nBits;
    logic [8:0] shf;
    logic usePar;
    logic par;
    logic stopBit;
    logic [6:0] gap;
    logic txBit;
    logic busy;
    logic done;
  } inj_t;

  inj_t q_ff, nxt_q;

  always_comb begin
    logic tick;
    logic [8:0] dm;
    logic [15:0] dv;
    tick = 1'b0;
    dm = '0;
    dv = cfg[CFG_DIV_LSB +: 16];
    nxt_q = q_ff;
    nxt_q.done = 1'b0;
    if (dv == 16'h0000) begin
      dv = 16'h0001;
    end
    // per-bit rate is a one-cycle enable from this divider
    if (q_ff.st != INJ_IDLE) begin
      tick = (q_ff.cnt == 16'h0000);
      nxt_q.cnt = tick ? q_ff.div : q_ff.cnt - 16'h0001;
    end
    case (q_ff.st)
      INJ_IDLE: begin
        if (brkStart) begin
          nxt_q.st = INJ_BRK;
          nxt_q.div = dv - 16'h0001;
          nxt_q.cnt = dv - 16'h0001;
          nxt_q.left = (brkLen < BRK_MIN) ? BRK_MIN : brkLen;
          nxt_q.txBit = 1'b0; // [RULE11]
          nxt_q.busy = 1'b1;
        end else if (start) begin
          nxt_q.st = INJ_START;
          nxt_q.div = dv - 16'h0001;
          nxt_q.cnt = dv - 16'h0001;
          nxt_q.shf = data;
          // one data bit short gives the receiver a wrong frame length
          nxt_q.nBits = (cfg[CFG_NINE] ? BITS_9 : BITS_8) - {3'h0, cfg[CFG_DROP_BIT]}; // [RULE9] [RULE10]
          for (int i = 0; i < 9; i++) begin
            dm[i] = data[i] & (4'(i) < nxt_q.nBits);
          end
          nxt_q.usePar = (cfg[CFG_PAR_LSB +: 2] != PAR_NONE);
          nxt_q.par = ^dm ^ (cfg[CFG_PAR_LSB +: 2] == PAR_ODD) ^ cfg[CFG_PAR_ERR]; // [RULE10]
          nxt_q.stopBit = !cfg[CFG_SHORT_STOP]; // [RULE10]
          nxt_q.gap = (gap < GAP_MIN) ? GAP_MIN : gap; // [RULE8]
          nxt_q.bitCnt = 4'h0;
          nxt_q.txBit = 1'b0;
          nxt_q.busy = 1'b1;
        end
      end
      INJ_START: begin
        if (tick) begin
          nxt_q.st = INJ_DATA;
          nxt_q.txBit = q_ff.shf[0];
          nxt_q.shf = q_ff.shf >> 1;
          nxt_q.bitCnt = 4'h1;
        end
      end
      INJ_DATA: begin
        if (tick) begin
          if (q_ff.bitCnt == q_ff.nBits) begin
            nxt_q.st = q_ff.usePar ? INJ_PAR : INJ_STOP;
            nxt_q.txBit = q_ff.usePar ? q_ff.par : q_ff.stopBit;
          end else begin
            nxt_q.txBit = q_ff.shf[0]; // [RULE9]
            nxt_q.shf = q_ff.shf >> 1;
            nxt_q.bitCnt = q_ff.bitCnt + 4'h1;
          end
        end
      end
      INJ_PAR: begin
        if (tick) begin
          nxt_q.st = INJ_STOP;
          nxt_q.txBit = q_ff.stopBit;
        end
      end
      INJ_STOP: begin
        if (tick) begin
          nxt_q.txBit = 1'b1;
          if (q_ff.gap == GAP_MIN) begin
            nxt_q.st = INJ_IDLE;
            nxt_q.busy = 1'b0;
            nxt_q.done = 1'b1;
          end else begin
            nxt_q.st = INJ_GAP;
            nxt_q.left = {9'h000, q_ff.gap - GAP_MIN}; // [RULE8]
          end
        end
      end
      INJ_GAP, INJ_BRK: begin
        if (tick) begin
          if (q_ff.left == 16'h0001) begin
            nxt_q.st = INJ_IDLE;
            nxt_q.txBit = 1'b1;
            nxt_q.busy = 1'b0;
            nxt_q.done = 1'b1;
          end else begin
            nxt_q.left = q_ff.left - 16'h0001; // [RULE8] [RULE11]
          end
        end
      end
      default: begin
        nxt_q.st = INJ_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      q_ff <= '{st: INJ_IDLE, txBit: 1'b1, default: '0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign txBit = q_ff.txBit;
  assign busy = q_ff.busy;
  assign done = q_ff.done;
endmodule

// [logic/serial_line_router_injector.sv]
// two-port serial line router with push button, taps and data injector
//
// Overview of operation
// RULE1: routing changes only when software applies it
// RULE2: button drives port A RTS negative while pressed
// RULE3: looped circuit is refused, routing left untouched
// RULE4: default routes each port A line 1:1 to B
// RULE5: default taps sample both data lines
// RULE6: undriven output lines are forced off
// RULE7: injector source replaces pass-through on its line
// RULE8: inter-byte gap of 1 to 127 baud clocks
// RULE9: nine-bit characters with the same gaps
// RULE10: deliberate parity, data-count or stop-bit errors
// RULE11: break holds transmit logic zero for set time
// RULE12: tap samples input side or pre-output side
// RULE13: reset restores default straight-through routing
// RULE14: new routing takes over on one clock edge
`timescale 1ns/1ps
module serial_line_router_injector (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [line_router_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq,
  input wire logic [3:0] portAIn,
  input wire logic [3:0] portBIn,
  output logic [3:0] portAOut,
  output logic [3:0] portBOut,
  output logic [1:0] tapData
);
  import line_router_pkg::*;

  typedef struct packed {
    logic [7:0][4:0] routeNew;
    logic [7:0][4:0] routeAct;
    logic btn;
    logic tapPost;
    logic fault;
    logic [IRQ_W-1:0] irqStat;
    logic [IRQ_W-1:0] irqMask;
    logic [CFG_W-1:0] injCfg;
    logic [7:0] tapSel;
    logic injStart;
    logic brkStart;
    logic [8:0] txData;
    logic [6:0] txGap;
    logic [15:0] brkLen;
    logic waitReq;
    logic [31:0] rdata;
    logic [3:0] portAOut;
    logic [3:0] portBOut;
    logic [1:0] tap;
    logic irq;
  } state_t;

  localparam state_t ST_RESET = '{
    routeNew: ROUTE_DEFAULT,
    routeAct: ROUTE_DEFAULT,
    injCfg: CFG_RESET,
    tapSel: TAP_RESET,
    waitReq: 1'b1,
    default: '0
  };

  state_t st_ff, nxt_st;
  logic injTx;
  logic injBusy;
  logic injDone;

  // walk a chain of output-to-output links to its real source;
  // eight steps cover every output once
  function automatic logic [4:0] followSrc(input logic [7:0][4:0] rt, input logic [4:0] s);
    logic [4:0] c;
    c = s;
    for (int i = 0; i < 8; i++) begin
      if (c[4:3] == SRC_KIND_OUT) begin
        c = rt[c[2:0]];
      end
    end
    return c;
  endfunction

  function automatic logic hasLoop(input logic [7:0][4:0] rt);
    logic l;
    logic [4:0] c;
    l = 1'b0;
    c = '0;
    // still on an output after eight steps can only mean a loop
    for (int j = 0; j < 8; j++) begin
      c = followSrc(rt, rt[j]);
      if (c[4:3] == SRC_KIND_OUT) begin
        l = 1'b1; // [RULE3]
      end
    end
    return l;
  endfunction

  // line level, 1 = positive voltage
  function automatic logic lineLevel(input logic [7:0][4:0] rt, input logic [2:0] j,
                                     input logic [7:0] ins, input logic btn,
                                     input logic tx);
    logic [4:0] c;
    logic v;
    c = followSrc(rt, rt[j]);
    if (c[4:3] == SRC_KIND_IN) begin
      v = ins[c[2:0]]; // [RULE4]
    end else if (c == SRC_HIGH) begin
      v = 1'b1;
    end else if (c == SRC_BTN) begin
      v = !btn; // [RULE2]
    end else if (c == SRC_INJ) begin
      v = !tx; // [RULE7]
    end else begin
      v = 1'b0; // [RULE6]
    end
    return v;
  endfunction

  // route words sit on one page, one word per output line
  function automatic logic isRoutePage(input logic [ADDR_W-1:0] a);
    return (a[7:5] == ROUTE_PAGE) && (a[1:0] == 2'h0);
  endfunction

  // one mask bit per data bit, taken from the byte enables
  function automatic logic [31:0] laneMask(input logic [3:0] be);
    logic [31:0] k;
    k = '0;
    for (int b = 0; b < 4; b++) begin
      k[b*8 +: 8] = {8{be[b]}};
    end
    return k;
  endfunction

  // post tap reads the output fed by the same input in the 1:1 map
  function automatic logic tapPick(input logic post, input logic [2:0] sel,
                                   input logic [7:0] ins, input logic [7:0] lvl);
    return post ? lvl[sel ^ 3'h4] : ins[sel];
  endfunction

  // read view of every register except the injector data and break words, which read zero; reserved bits stay zero
  function automatic logic [31:0] regRead(input state_t s, input logic [ADDR_W-1:0] a,
                                          input logic busyNow);
    logic [31:0] r;
    r = '0;
    if (a == OFS_CTRL) begin
      r[CTRL_BTN] = s.btn;
      r[CTRL_TAP_POST] = s.tapPost;
    end else if (a == OFS_STATUS) begin
      r[STAT_FAULT] = s.fault;
      r[STAT_INJ_BUSY] = busyNow;
    end else if (a == OFS_IRQ_STAT) begin
      r[IRQ_W-1:0] = s.irqStat;
    end else if (a == OFS_IRQ_MASK) begin
      r[IRQ_W-1:0] = s.irqMask;
    end else if (a == OFS_INJ_CFG) begin
      r[CFG_W-1:0] = s.injCfg;
    end else if (a == OFS_TAP_SEL) begin
      r[7:0] = s.tapSel;
    end else if (isRoutePage(a)) begin
      r[4:0] = s.routeNew[a[4:2]];
    end
    return r;
  endfunction

  always_comb begin
    logic req;
    logic accept;
    logic take;
    logic injWr;
    logic [31:0] m;
    logic [7:0] ins;
    logic [7:0] lvl;
    logic [2:0] sel;
    logic [7:0][4:0] nr;
    logic [IRQ_W-1:0] ev;
    req = read | write;
    accept = 1'b0;
    take = 1'b0;
    injWr = 1'b0;
    m = '0;
    ins = {portBIn, portAIn};
    lvl = '0;
    sel = '0;
    nr = st_ff.routeNew;
    ev = '0;
    nxt_st = st_ff;
    nxt_st.injStart = 1'b0;
    nxt_st.brkStart = 1'b0;
    m = laneMask(byteenable);
    // injector words stall the bus until the injector can take them
    injWr = write && (address == OFS_INJ_DATA || address == OFS_INJ_BREAK);
    accept = req && st_ff.waitReq && !(injWr && (injBusy || st_ff.injStart || st_ff.brkStart));
    take = req && !st_ff.waitReq;
    nxt_st.waitReq = !accept;

    // loaded on the accept edge so the word stands at the ack edge
    if (accept && read) begin
      nxt_st.rdata = regRead(st_ff, address, injBusy);
    end

    // writes land on the edge where the master sees waitrequest low
    if (take && write) begin
      if (address == OFS_CTRL) begin
        if (byteenable[0]) begin
          nxt_st.btn = writedata[CTRL_BTN]; // [RULE2]
          nxt_st.tapPost = writedata[CTRL_TAP_POST]; // [RULE12]
          if (writedata[CTRL_LOAD_DFLT]) begin
            nr = ROUTE_DEFAULT;
          end
          nxt_st.routeNew = nr;
          if (writedata[CTRL_APPLY]) begin
            if (hasLoop(nr)) begin
              nxt_st.fault = 1'b1; // [RULE3]
              ev[IRQ_FAULT] = 1'b1;
            end else begin
              // whole table swaps at once, never a mix of old and new
              nxt_st.routeAct = nr; // [RULE1] [RULE14]
              nxt_st.fault = 1'b0;
              ev[IRQ_APPLIED] = 1'b1;
            end
          end
        end
      end else if (address == OFS_IRQ_STAT) begin
        nxt_st.irqStat = st_ff.irqStat & ~(writedata[IRQ_W-1:0] & m[IRQ_W-1:0]);
      end else if (address == OFS_IRQ_MASK) begin
        if (byteenable[0]) begin
          nxt_st.irqMask = writedata[IRQ_W-1:0];
        end
      end else if (address == OFS_INJ_CFG) begin
        nxt_st.injCfg = (st_ff.injCfg & ~m[CFG_W-1:0]) | (writedata[CFG_W-1:0] & m[CFG_W-1:0]);
      end else if (address == OFS_INJ_DATA) begin
        nxt_st.txData = writedata[DATA_LSB +: 9];
        nxt_st.txGap = writedata[GAP_LSB +: 7]; // [RULE8]
        nxt_st.injStart = 1'b1;
      end else if (address == OFS_INJ_BREAK) begin
        nxt_st.brkLen = writedata[15:0];
        nxt_st.brkStart = 1'b1; // [RULE11]
      end else if (address == OFS_TAP_SEL) begin
        if (byteenable[0]) begin
          nxt_st.tapSel = writedata[7:0];
        end
      end else if (isRoutePage(address)) begin
        if (byteenable[0]) begin
          nxt_st.routeNew[address[4:2]] = writedata[4:0]; // [RULE1]
        end
      end
    end

    // a fresh event beats a clear in the same cycle
    ev[IRQ_INJ_DONE] = injDone;
    nxt_st.irqStat = nxt_st.irqStat | ev;
    nxt_st.irq = |(nxt_st.irqStat & nxt_st.irqMask);

    // lines follow the active table only, so staged edits never leak out
    for (int j = 0; j < 8; j++) begin
      lvl[j] = lineLevel(st_ff.routeAct, 3'(j), ins, st_ff.btn, injTx);
    end
    nxt_st.portAOut = lvl[3:0];
    nxt_st.portBOut = lvl[7:4];

    for (int t = 0; t < 2; t++) begin
      sel = st_ff.tapSel[t*4 +: 3];
      nxt_st.tap[t] = tapPick(st_ff.tapPost, sel, ins, lvl); // [RULE5] [RULE12]
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_ff <= ST_RESET; // [RULE13] [RULE4] [RULE5]
    end else begin
      st_ff <= nxt_st;
    end
  end

  // same clock as the router; the bit rate is the injector's own divider
  char_injector u_inj (
    .ref_clk(ref_clk),
    .reset(reset),
    .start(st_ff.injStart),
    .data(st_ff.txData),
    .gap(st_ff.txGap),
    .brkStart(st_ff.brkStart),
    .brkLen(st_ff.brkLen),
    .cfg(st_ff.injCfg),
    .txBit(injTx),
    .busy(injBusy),
    .done(injDone)
  );

  assign readdata = st_ff.rdata;
  assign waitrequest = st_ff.waitReq;
  assign irq = st_ff.irq;
  assign portAOut = st_ff.portAOut;
  assign portBOut = st_ff.portBOut;
  assign tapData = st_ff.tap;
endmodule

// [verification/line_router_asserts.sv]
// assertion checker for the two-port line router
`timescale 1ns/1ps
module line_router_asserts (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [line_router_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic irq,
  input wire logic [3:0] portAIn,
  input wire logic [3:0] portBIn,
  input wire logic [3:0] portAOut,
  input wire logic [3:0] portBOut,
  input wire logic [1:0] tapData
);
  import line_router_pkg::*;
  typedef struct packed {
    logic dflt;
    logic post;
    logic [2:0] sel0;
    logic [2:0] sel1;
    logic [2:0] mask;
    logic [1:0] tapExp;
  } chkState_t;
  chkState_t st_ff;
  chkState_t nxt_st;
  logic [7:0] ins;
  assign ins = {portBIn, portAIn};
  // mirror only what the checks need; any control write ends the default claim
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tapExp = {ins[st_ff.sel1], ins[st_ff.sel0]};
    if (write && !waitrequest && byteenable[0]) begin
      if (address == OFS_CTRL) begin
        nxt_st.dflt = 1'h0;
        nxt_st.post = writedata[CTRL_TAP_POST];
      end
      if (address == OFS_TAP_SEL) begin
        nxt_st.dflt = 1'h0;
        nxt_st.sel0 = writedata[2:0];
        nxt_st.sel1 = writedata[6:4];
      end
      if (address == OFS_IRQ_MASK) nxt_st.mask = writedata[2:0];
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) st_ff <= {1'h1, 1'h0, 3'h0, 3'h4, 3'h0, 2'h0};
    else st_ff <= nxt_st;
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  AST_ROUTE_DEFAULT:
    assert property (st_ff.dflt && !$past(reset) |->
      portBOut == $past(portAIn) && portAOut == $past(portBIn)) else $error("not 1:1");
  AST_RESET_RESTORE:
    assert property ($fell(reset) |-> ##1 (portBOut == $past(portAIn) &&
      portAOut == $past(portBIn))) else $error("reset routing wrong");
  AST_TAP_DEFAULT:
    assert property (st_ff.dflt && !$past(reset) |->
      tapData == {$past(portBIn[0]), $past(portAIn[0])}) else $error("tap default wrong");
  AST_TAP_INPUT:
    assert property (!st_ff.post && !$past(st_ff.post) && !$past(reset) |->
      tapData == st_ff.tapExp) else $error("input tap wrong");
  AST_ACK_ONE:
    assert property (!waitrequest |=> waitrequest) else $error("ack too long");
  AST_ACK_CAUSE:
    assert property (!waitrequest |-> $past(read) || $past(write)) else $error("ack no request");
  AST_READ_HOLD:
    assert property (!$past(read && waitrequest) |-> $stable(readdata))
      else $error("readdata moved");
  AST_IRQ_MASKED:
    assert property (st_ff.mask == 3'h0 && $past(st_ff.mask) == 3'h0 && !$past(reset)
      |-> !irq) else $error("masked irq");
  cover property (write && !waitrequest && address == OFS_CTRL);
  cover property ($rose(irq));
  cover property (st_ff.post && tapData[0]);
endmodule
bind serial_line_router_injector line_router_asserts u_chk (.ref_clk, .reset, .address, .read,
  .write, .writedata, .byteenable, .readdata, .waitrequest, .irq, .portAIn, .portBIn,
  .portAOut, .portBOut, .tapData);

// [verification/rs232_partner.sv]
// behavioural model of the serial devices on ports A and B
`timescale 1ns/1ps
module rs232_partner (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [3:0] aWant,
  input wire logic [3:0] bWant,
  output logic [3:0] portAIn,
  output logic [3:0] portBIn
);
  // lines move just after an edge; mark (low) while in reset
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      portAIn <= 4'h0;
      portBIn <= 4'h0;
    end else begin
      portAIn <= aWant;
      portBIn <= bWant;
    end
  end
endmodule

// [verification/test_serial_line_router_injector.sv]
// self-checking bench for the line router and injector
`timescale 1ns/1ps
module test_serial_line_router_injector;
  import line_router_pkg::*;
  localparam int DIV = 8;
  logic ref_clk = 1'h0;
  logic reset = 1'h1;
  logic [7:0] address = 8'h00;
  logic read = 1'h0;
  logic write = 1'h0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hF;
  logic [3:0] aWant = 4'h5;
  logic [3:0] bWant = 4'hA;
  logic [31:0] readdata, rd;
  logic waitrequest, irq;
  logic [3:0] portAIn, portBIn, portAOut, portBOut;
  logic [1:0] tapData;
  logic [11:0] v;
  logic [31:0] fCfg [5] = '{32'h8, 32'h80008, 32'h150008, 32'h200008, 32'h20008};
  logic [8:0] fDat [5] = '{9'h05A, 9'h1A5, 9'h001, 9'h07F, 9'h003};
  logic [11:0] fExp [5] = '{12'h15A, 12'h3A5, 12'h001, 12'h0FF, 12'h303};
  int fNb [5] = '{9, 10, 10, 8, 10};
  logic [6:0] gaps [2] = '{7'h01, 7'h7F};
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int s1, s2, n;
  serial_line_router_injector u_dut (.ref_clk, .reset, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .irq, .portAIn, .portBIn, .portAOut, .portBOut,
    .tapData);
  rs232_partner u_peer (.ref_clk, .reset, .aWant, .bWant, .portAIn, .portBIn);
  always #4 ref_clk = ~ref_clk;
  // whole run needs a few thousand cycles
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // signals move just after a rising edge; ack and data are taken at the edge itself
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ack;
    @(posedge ref_clk);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    ack = 1'h0;
    while (!ack) begin
      @(posedge ref_clk);
      ack = (waitrequest === 1'h0);
      rd = readdata;
    end
    write <= 1'h0;
    read <= 1'h0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic pchk(input logic [9:0] exp);
    repeat (3) @(negedge ref_clk);
    chk({22'h0, tapData, portAOut, portBOut}, {22'h0, exp});
  endtask
  task automatic idle();
    do bus(1'h0, OFS_STATUS, 32'h0); while (rd[STAT_INJ_BUSY] !== 1'h0);
  endtask
  // injector drives port B data line; pin high means logic zero
  task automatic cap(input int nb, output logic [11:0] val, output int st);
    val = 12'h0;
    do @(negedge ref_clk); while (portBOut[0] !== 1'h1);
    st = cyc;
    repeat (DIV / 2) @(negedge ref_clk);
    for (int i = 0; i < nb; i++) begin
      repeat (DIV) @(negedge ref_clk);
      val[i] = ~portBOut[0];
    end
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    reset <= 1'h0;
    @(posedge ref_clk);
    pchk({2'h1, 4'hA, 4'h5});
    for (int k = 0; k < 8; k++) rdchk(8'h20 + 8'(4 * k), 32'(k ^ 4));
    rdchk(OFS_TAP_SEL, 32'(TAP_RESET));
    rdchk(OFS_INJ_CFG, 32'(CFG_RESET));
    rdchk(OFS_IRQ_MASK, 32'h0);
    bus(1'h1, 8'hFC, 32'hFFFFFFFF);
    rdchk(8'hFC, 32'h0);
    $display("test defaults done");
    bus(1'h1, OFS_IRQ_MASK, 32'h7);
    bus(1'h1, 8'h20, 32'(SRC_HIGH));
    bus(1'h1, 8'h30, 32'h11);
    pchk({2'h1, 4'hA, 4'h5});
    bus(1'h1, OFS_CTRL, 32'h1 << CTRL_APPLY);
    repeat (3) @(negedge ref_clk) chk(32'((portAOut === 4'hA) == (portBOut === 4'h5)), 1);
    pchk({2'h1, 4'hB, 4'h4});
    chk({31'h0, irq}, 32'h1);
    rdchk(OFS_IRQ_STAT, 32'h1);
    bus(1'h1, OFS_IRQ_STAT, 32'h1);
    rdchk(OFS_IRQ_STAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test apply done");
    bus(1'h1, OFS_IRQ_MASK, 32'h0);
    bus(1'h1, 8'h24, 32'h9);
    bus(1'h1, OFS_CTRL, 32'h1 << CTRL_APPLY);
    pchk({2'h1, 4'hB, 4'h4});
    rdchk(OFS_STATUS, 32'h1);
    rdchk(OFS_IRQ_STAT, 32'h2);
    chk({31'h0, irq}, 32'h0);
    bus(1'h1, OFS_IRQ_STAT, 32'h2);
    bus(1'h1, 8'h24, 32'h5);
    $display("test loop done");
    bus(1'h1, 8'h28, 32'(SRC_BTN));
    bus(1'h1, OFS_CTRL, 32'h1 << CTRL_APPLY);
    pchk({2'h1, 4'hF, 4'h4});
    bus(1'h1, OFS_CTRL, 32'h1 << CTRL_BTN);
    pchk({2'h1, 4'hB, 4'h4});
    bus(1'h1, OFS_CTRL, 32'h0);
    pchk({2'h1, 4'hF, 4'h4});
    $display("test button done");
    bus(1'h1, OFS_TAP_SEL, 32'h16);
    pchk({2'h0, 4'hF, 4'h4});
    bus(1'h1, OFS_CTRL, 32'h1 << CTRL_TAP_POST);
    pchk({2'h1, 4'hF, 4'h4});
    bus(1'h1, OFS_CTRL, (32'h1 << CTRL_TAP_POST) | (32'h1 << CTRL_BTN));
    pchk({2'h0, 4'hB, 4'h4});
    $display("test taps done");
    bus(1'h1, 8'h30, 32'(SRC_INJ));
    bus(1'h1, OFS_CTRL, 32'h1 << CTRL_APPLY);
    pchk({2'h0, 4'hF, 4'h4});
    for (int f = 0; f < 5; f++) begin
      bus(1'h1, OFS_INJ_CFG, fCfg[f]);
      bus(1'h1, OFS_INJ_DATA, {23'h1, fDat[f]});
      cap(fNb[f], v, s1);
      chk(32'(v), 32'(fExp[f]));
      idle();
    end
    bus(1'h1, OFS_INJ_CFG, 32'(DIV));
    foreach (gaps[g]) begin
      fork
        begin
          bus(1'h1, OFS_INJ_DATA, {9'h0, gaps[g], 7'h0, 9'h055});
          bus(1'h1, OFS_INJ_DATA, {9'h0, gaps[g], 7'h0, 9'h055});
        end
        begin
          cap(9, v, s1);
          cap(9, v, s2);
        end
      join
      n = s2 - s1 - (9 + int'(gaps[g])) * DIV;
      chk(32'(n >= 0 && n <= DIV), 32'h1);
      chk(32'(v), 32'h155);
      idle();
    end
    bus(1'h1, OFS_IRQ_STAT, 32'h7);
    bus(1'h1, OFS_IRQ_MASK, 32'h4);
    bus(1'h1, OFS_INJ_BREAK, 32'h5);
    do @(negedge ref_clk); while (portBOut[0] !== 1'h1);
    n = 0;
    while (portBOut[0] === 1'h1) begin
      n++;
      @(negedge ref_clk);
    end
    chk(32'(n >= 5 * DIV - 2 && n <= 5 * DIV + 2), 32'h1);
    idle();
    rdchk(OFS_IRQ_STAT, 32'h4);
    chk({31'h0, irq}, 32'h1);
    $display("test injector done");
    reset <= 1'h1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'h0;
    @(posedge ref_clk);
    pchk({2'h1, 4'hA, 4'h5});
    rdchk(8'h30, 32'h0);
    $display("test second reset done");
    aWant <= 4'hC;
    bWant <= 4'h3;
    bus(1'h1, 8'h20, 32'h11);
    bus(1'h1, OFS_CTRL, (32'h1 << CTRL_LOAD_DFLT) | (32'h1 << CTRL_APPLY));
    pchk({2'h2, 4'h3, 4'hC});
    rdchk(8'h20, 32'h4);
    $display("test load default done");
    conclude();
  end
endmodule
